// >>> wiper_control.sv
// Command core of the dual wiper serial control
// How it works
// R1 - A save to nonvolatile store takes 25 ms.
// R2 - Serial shift register is locked while a save runs.
// R3 - save_done output reports save completion.
// R4 - Wiper outputs follow the wiper setting registers directly.
// R5 - Command 11 loads the data byte into the addressed wiper.
// R6 - Command 2 copies the addressed wiper into its store location.
// R7 - After reset wipers load from the nonvolatile store.
// R8 - Store locations hold midscale before any save.
// R9 - Preset low forces midscale; its rise reloads from store.
// R10 - Step and 6 dB shift commands adjust the wipers.
// R11 - Later bare strobes repeat a loaded step or shift command.
// R12 - Write protect blocks wiper changes except reloads and preset.
// R13 - Host sends a no-op before releasing write protect.
// R14 - Host sends 16-bit words most significant bit first.
// R15 - Word executes only when chip select rises.
// R16 - No-op command puts the block into idle.
// R17 - Only frames of a multiple of 16 bits execute.
// R18 - Bit count clears on chip select rise; data kept at multiples of 4.
// R19 - Chip select pulse without clocks repeats previous command.
// R20 - Serial output is released while chip select is high.
// R21 - Works in clock modes 0,0 and 1,1.
// R22 - Word holds command, address and data nibbles/byte.
// R23 - One input bit sampled per serial clock rising edge.
// R24 - Commands other than 9 and 10 echo input delayed 16 clocks on serial out.
// R25 - Command 9 places the addressed store byte for readback.
// R26 - Increment and left shift saturate at all ones.
// R27 - save_done drops at save start, returns after save time.
module wiper_control
	import wiper_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic cs_n,
	input wire logic preset_reload_n,
	input wire logic write_protect_n,
	output logic sdo_out,
	output logic sdo_oe,
	output logic save_done,
	output logic idle,
	output logic [7:0] wiper_terminal_one,
	output logic [7:0] wiper_terminal_two
);
	typedef enum {ST_BOOT, ST_RUN, ST_SAVE} state_type;

	serial_link_if link ();
	logic [2:0] pr_sync, wp_sync;
	logic pr_prev;
	state_type state, next_state;
	logic [7:0] wiper_setting_reg [2], next_wiper [2];
	// Store survives reset, standing in for real nonvolatile cells
	logic [7:0] nonvolatile_store [16] = '{default: MIDSCALE}; // R8
	logic [7:0] next_store [16];
	logic [31:0] timer, next_timer;
	logic [3:0] last_cmd, next_last_cmd;
	logic [3:0] last_addr, next_last_addr;
	logic next_idle, ran_once, next_ran_once;
	logic [3:0] cmd, addr;
	logic [7:0] data;
	logic pr_low, pr_rise, wp_on, bare_strobe, valid_frame;

	// Saturating step and shift of one setting
	function automatic logic [7:0] adjust(input logic [3:0] c,
		input logic [7:0] v);
		logic [7:0] r;
		r = v;
		case (c)
			CMD_SHR_ONE, CMD_SHR_ALL: r = v >> 1;
			CMD_DEC_ONE, CMD_DEC_ALL: r = (v == ALL_ZERO) ? v : v - 8'h01;
			CMD_SHL_ONE, CMD_SHL_ALL: r = v[7] ? ALL_ONES : v << 1; // R26
			CMD_INC_ONE, CMD_INC_ALL: r = (v == ALL_ONES) ? v : v + 8'h01;
			default: r = v;
		endcase
		return r;
	endfunction

	function automatic logic is_repeatable(input logic [3:0] c);
		return c >= CMD_SHR_ONE && c <= CMD_DEC_ALL
			|| c >= CMD_SHL_ONE;
	endfunction

	function automatic logic hits_all(input logic [3:0] c);
		return c == CMD_SHR_ALL || c == CMD_DEC_ALL
			|| c == CMD_SHL_ALL || c == CMD_INC_ALL;
	endfunction

	serial_front front (
		.mclk(mclk),
		.rst(rst),
		.sclk_pin(sclk),
		.sdi_pin(sdi),
		.cs_n_pin(cs_n),
		.sdo_out(sdo_out),
		.sdo_oe(sdo_oe),
		.link(link.front)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers for preset and write protect
	always_ff @(posedge mclk) begin
		if (rst) begin
			pr_sync <= 3'h7;
			wp_sync <= 3'h7;
			pr_prev <= 1'b1;
		end else begin
			pr_sync <= {pr_sync[1:0], preset_reload_n};
			wp_sync <= {wp_sync[1:0], write_protect_n};
			pr_prev <= pr_sync[1];
		end
	end

	assign pr_low = ~pr_sync[1];
	assign pr_rise = pr_sync[1] & ~pr_prev;
	assign wp_on = ~wp_sync[1];
	assign cmd = link.word[CMD_HI:CMD_LO]; // R22
	assign addr = link.word[CMD_LO-1:ADDR_LO]; // R22
	assign data = link.word[ADDR_LO-1:0]; // R22
	assign valid_frame = link.frame_end && link.bit_count != '0
		&& link.bit_count[3:0] == 4'h0; // R17 R15
	assign bare_strobe = link.frame_end && link.bit_count == '0;
	assign link.lock = (state == ST_SAVE); // R2

	////////////////////////////////////////////////////////////////////////
	// Command execution
	always_comb begin
		logic [3:0] ec;
		logic [3:0] ea;
		logic go;
		ec = cmd;
		ea = addr;
		go = 1'b0;
		next_state = state;
		next_wiper = wiper_setting_reg;
		next_store = nonvolatile_store;
		next_timer = timer;
		next_last_cmd = last_cmd;
		next_last_addr = last_addr;
		next_idle = idle;
		next_ran_once = ran_once;
		link.load = 1'b0;
		link.load_word = link.word;
		case (state)
			ST_BOOT: begin
				next_wiper[0] = nonvolatile_store[0]; // R7
				next_wiper[1] = nonvolatile_store[1];
				next_state = ST_RUN;
			end
			ST_RUN: begin
				if (valid_frame) begin
					go = 1'b1;
					next_ran_once = 1'b1;
				end else if (bare_strobe && ran_once) begin // R19 R11
					go = 1'b1;
					ec = last_cmd;
					ea = last_addr;
				end
				if (go) begin
					next_last_cmd = ec;
					next_last_addr = ea;
					next_idle = (ec == CMD_NOP); // R16
					case (ec)
						CMD_WRITE: if (!wp_on)
							next_wiper[ea[0]] = data; // R5 R12
						CMD_SAVE: begin
							next_store[ea[0]] = wiper_setting_reg[ea[0]]; // R6
							next_timer = SAVE_CYCLES - 1; // R1
							next_state = ST_SAVE; // R27
						end
						CMD_STORE_DATA: begin
							next_store[ea] = data;
							next_timer = SAVE_CYCLES - 1;
							next_state = ST_SAVE;
						end
						CMD_RELOAD_ONE:
							next_wiper[ea[0]] = nonvolatile_store[ea[0]];
						CMD_RELOAD_ALL: begin
							next_wiper[0] = nonvolatile_store[0]; // R12
							next_wiper[1] = nonvolatile_store[1];
						end
						CMD_READ_STORE: begin
							link.load = 1'b1; // R25
							link.load_word = {link.word[15:8],
								nonvolatile_store[ea]};
						end
						CMD_READ_WIPER: begin
							link.load = 1'b1;
							link.load_word = {link.word[15:8],
								wiper_setting_reg[ea[0]]};
						end
						default: if (is_repeatable(ec) && !wp_on) begin // R10
							if (hits_all(ec)) begin
								next_wiper[0] = adjust(ec, wiper_setting_reg[0]);
								next_wiper[1] = adjust(ec, wiper_setting_reg[1]);
							end else begin
								next_wiper[ea[0]] =
									adjust(ec, wiper_setting_reg[ea[0]]);
							end
						end
					endcase
				end
			end
			ST_SAVE: begin
				if (timer == '0) begin
					next_state = ST_RUN;
				end else begin
					next_timer = timer - 1;
				end
			end
			default: next_state = ST_BOOT;
		endcase
		if (pr_low) begin
			next_wiper[0] = MIDSCALE; // R9
			next_wiper[1] = MIDSCALE;
		end else if (pr_rise) begin
			next_wiper[0] = nonvolatile_store[0]; // R9
			next_wiper[1] = nonvolatile_store[1];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_BOOT;
			wiper_setting_reg <= '{default: MIDSCALE};
			timer <= '0;
			last_cmd <= CMD_NOP;
			last_addr <= 4'h0;
			idle <= 1'b1;
			ran_once <= 1'b0;
		end else begin
			state <= next_state;
			wiper_setting_reg <= next_wiper;
			timer <= next_timer;
			last_cmd <= next_last_cmd;
			last_addr <= next_last_addr;
			idle <= next_idle;
			ran_once <= next_ran_once;
		end
	end

	always_ff @(posedge mclk) begin
		nonvolatile_store <= next_store;
	end

	assign save_done = (state != ST_SAVE); // R3 R27
	assign wiper_terminal_one = wiper_setting_reg[0]; // R4
	assign wiper_terminal_two = wiper_setting_reg[1];

	////////////////////////////////////////////////////////////////////////
	// Checks
	sequence save_start_s;
		state == ST_RUN && next_state == ST_SAVE;
	endsequence
	chk_save_done_low: assert property (@(posedge mclk) disable iff (rst)
		save_start_s |=> !save_done) else $error("save_done not low"); // R27
	chk_save_lock: assert property (@(posedge mclk) disable iff (rst)
		!save_done |-> link.lock) else $error("lock missing"); // R2
	chk_preset_mid: assert property (@(posedge mclk) disable iff (rst)
		pr_low |=> wiper_terminal_one == MIDSCALE
		&& wiper_terminal_two == MIDSCALE) else $error("preset"); // R9
	chk_write_exec: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && valid_frame && cmd == CMD_WRITE && !wp_on
		&& !pr_low && !pr_rise && addr[0] == 1'b0
		|=> wiper_terminal_one == $past(data)) else $error("write"); // R5
	chk_wp_block: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && valid_frame && cmd == CMD_WRITE && wp_on
		&& !pr_low && !pr_rise
		|=> $stable(wiper_terminal_one) && $stable(wiper_terminal_two))
		else $error("protect"); // R12
	chk_sdo_release: assert property (@(posedge mclk) disable iff (rst)
		$past(front.cs_sync[1]) |-> !sdo_oe) else $error("sdo"); // R20
	chk_inc_sat: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && valid_frame && cmd == CMD_INC_ALL && !wp_on
		&& !pr_low && !pr_rise && wiper_terminal_one == ALL_ONES
		|=> wiper_terminal_one == ALL_ONES) else $error("sat"); // R26
	chk_save_len: assert property (@(posedge mclk) disable iff (rst)
		save_start_s |=> !save_done [*8]) else $error("short"); // R1
	chk_nop_idle: assert property (@(posedge mclk) disable iff (rst)
		state == ST_RUN && valid_frame && cmd == CMD_NOP |=> idle)
		else $error("idle"); // R16
endmodule // wiper_control

// >>> wiper_pkg.sv
// Shared constants for the dual wiper serial control block
package wiper_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned SAVE_MS = 25;
	localparam int unsigned SAVE_CYCLES = (CLK_HZ / 1000) * SAVE_MS;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 6;
	localparam logic [7:0] MIDSCALE = 8'h80;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] ALL_ZERO = 8'h00;
	localparam logic [1:0] QUAD_MASK = 2'h3;
	localparam logic [3:0] CMD_NOP = 4'h0;
	localparam logic [3:0] CMD_RELOAD_ONE = 4'h1;
	localparam logic [3:0] CMD_SAVE = 4'h2;
	localparam logic [3:0] CMD_STORE_DATA = 4'h3;
	localparam logic [3:0] CMD_SHR_ONE = 4'h4;
	localparam logic [3:0] CMD_SHR_ALL = 4'h5;
	localparam logic [3:0] CMD_DEC_ONE = 4'h6;
	localparam logic [3:0] CMD_DEC_ALL = 4'h7;
	localparam logic [3:0] CMD_RELOAD_ALL = 4'h8;
	localparam logic [3:0] CMD_READ_STORE = 4'h9;
	localparam logic [3:0] CMD_READ_WIPER = 4'ha;
	localparam logic [3:0] CMD_WRITE = 4'hb;
	localparam logic [3:0] CMD_SHL_ONE = 4'hc;
	localparam logic [3:0] CMD_SHL_ALL = 4'hd;
	localparam logic [3:0] CMD_INC_ONE = 4'he;
	localparam logic [3:0] CMD_INC_ALL = 4'hf;
	localparam int CMD_HI = 15;
	localparam int CMD_LO = 12;
	localparam int ADDR_LO = 8;
endpackage

// >>> serial_link_if.sv
// Interface between the serial front end and the command core
interface serial_link_if;
	logic [15:0] word;
	logic [5:0] bit_count;
	logic frame_end;
	logic lock;
	logic load;
	logic [15:0] load_word;
	modport front (output word, bit_count, frame_end,
		input lock, load, load_word);
	modport core (input word, bit_count, frame_end,
		output lock, load, load_word);
endinterface

// >>> serial_front.sv
// Serial shift register front end sampling the host pins on mclk
module serial_front
	import wiper_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic sclk_pin,
	input wire logic sdi_pin,
	input wire logic cs_n_pin,
	output logic sdo_out,
	output logic sdo_oe,
	serial_link_if.front link
);
	logic [2:0] sclk_sync, sdi_sync, cs_sync;
	logic sclk_prev, cs_prev;
	logic [15:0] shreg, next_shreg;
	logic [CNT_W-1:0] count, next_count;
	logic rise, frame_end;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sclk_sync <= '0;
			sdi_sync <= '0;
			cs_sync <= 3'h7;
			sclk_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			sclk_sync <= {sclk_sync[1:0], sclk_pin};
			sdi_sync <= {sdi_sync[1:0], sdi_pin};
			cs_sync <= {cs_sync[1:0], cs_n_pin};
			sclk_prev <= sclk_sync[1];
			cs_prev <= cs_sync[1];
		end
	end

	// Edge detection only looks at second-stage synchroniser outputs
	// Either idle level works: only rising edges inside a frame shift
	assign rise = sclk_sync[1] & ~sclk_prev & ~cs_sync[1]; // R21
	assign frame_end = cs_sync[1] & ~cs_prev;
	assign link.frame_end = frame_end;
	assign link.word = shreg;
	assign link.bit_count = count;

	always_comb begin
		next_shreg = shreg;
		next_count = count;
		if (link.load) begin
			next_shreg = link.load_word;
		end else if (rise && !link.lock) begin // R2 R23
			next_shreg = {shreg[14:0], sdi_sync[1]}; // R14
			next_count = count + 1'b1; // R17
		end
		// A ragged count is taken as noise, so its bits are dropped
		if (frame_end && (count[1:0] & QUAD_MASK) != 2'h0) begin
			next_shreg = '0; // R18
			next_count = '0; // R18
		end else if (frame_end) begin
			next_count = '0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			shreg <= '0;
			count <= '0;
			sdo_out <= 1'b0;
			sdo_oe <= 1'b0;
		end else begin
			shreg <= next_shreg;
			count <= next_count;
			// Open drain: drive only a low bit, never while deselected
			sdo_out <= 1'b0;
			// Bit 15 of the shift register is the input 16 clocks late
			sdo_oe <= ~cs_sync[1] & ~shreg[15]; // R20 R24
		end
	end
endmodule // serial_front

// >>> host_master_model.sv
// Host side serial master model driving the wiper control pins
module host_master_model (
	input wire logic mclk,
	input wire logic sdo_line,
	output logic sclk,
	output logic sdi,
	output logic cs_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic cpol = 1'b0;
	logic [31:0] rx = '0;
	initial begin
		sclk = 1'b0;
		sdi = 1'b0;
		cs_n = 1'b1;
	end
	////////////////////////////////////////////////////////////////////
	// Half a link clock period of 80 ns, always counted on mclk falls
	task automatic half();
		repeat (4) @(negedge mclk);
	endtask
	// Low n bits of w go out msb first; sdo is taken before each rise
	task automatic frame(input logic [31:0] w, input int n);
		rx = '0;
		sclk = cpol;
		half();
		cs_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b0;
			sdi = w[i];
			half();
			rx = {rx[30:0], sdo_line};
			sclk = 1'b1;
			half();
		end
		sclk = cpol;
		half();
		cs_n = 1'b1;
		// Released data line must not keep its last level
		sdi = ~sdi;
		half();
		half();
	endtask
	// Chip select pulse with the clock left idle
	task automatic strobe();
		cs_n = 1'b0;
		half();
		cs_n = 1'b1;
		half();
		half();
	endtask
endmodule // host_master_model

// >>> tb_wiper_control.sv
// Self-checking bench for the dual wiper serial control
module tb_wiper_control
	import wiper_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [15:0] w; logic [7:0] e1; logic [7:0] e2;} row_type;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic preset_reload_n = 1'b1;
	logic write_protect_n = 1'b1;
	logic sclk, sdi, cs_n, sdo_out, sdo_oe, save_done, idle, sdo_line;
	logic [7:0] wiper_terminal_one, wiper_terminal_two;
	int failures = 0;
	int checked = 0;
	int cycles = 0;
	row_type rows [15] = '{'{16'hb040, 8'h40, 8'h80}, '{16'hb1c0, 8'h40, 8'hc0},
		'{16'he000, 8'h41, 8'hc0}, '{16'hf000, 8'h42, 8'hc1},
		'{16'h6100, 8'h42, 8'hc0}, '{16'h7000, 8'h41, 8'hbf},
		'{16'hc000, 8'h82, 8'hbf}, '{16'hd000, 8'hff, 8'hff},
		'{16'h4000, 8'h7f, 8'hff}, '{16'h5000, 8'h3f, 8'h7f},
		'{16'h8000, 8'h80, 8'h80}, '{16'hb1fe, 8'h80, 8'hfe},
		'{16'he100, 8'h80, 8'hff}, '{16'he100, 8'h80, 8'hff},
		'{16'h0000, 8'h80, 8'hff}};
	// Open drain line with its pull-up
	assign sdo_line = sdo_oe ? sdo_out : 1'b1;
	always #5 mclk = ~mclk;
	wiper_control wiper_control_i (.mclk(mclk), .rst(rst), .sclk(sclk),
		.sdi(sdi), .cs_n(cs_n), .preset_reload_n(preset_reload_n),
		.write_protect_n(write_protect_n), .sdo_out(sdo_out),
		.sdo_oe(sdo_oe), .save_done(save_done), .idle(idle),
		.wiper_terminal_one(wiper_terminal_one),
		.wiper_terminal_two(wiper_terminal_two));
	host_master_model host_master_model_i (.mclk(mclk), .sdo_line(sdo_line),
		.sclk(sclk), .sdi(sdi), .cs_n(cs_n));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic expect_w(input logic [7:0] e1, input logic [7:0] e2);
		chk({8'h00, wiper_terminal_one}, {8'h00, e1});
		chk({8'h00, wiper_terminal_two}, {8'h00, e2});
		chk({15'h0000, sdo_oe}, 16'h0000);
	endtask
	task automatic send(input logic [31:0] w, input int n);
		host_master_model_i.frame(w, n);
	endtask
	task automatic pause(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// About 4500 cycles are needed; the ceiling leaves over twice that
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 10000) begin
			failures++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		pause(2);
		rst = 1'b0;
		pause(6);
		expect_w(MIDSCALE, MIDSCALE);
		chk({15'h0000, save_done}, 16'h0001);
		$display("test reset done");
		for (int i = 0; i < 15; i++) begin
			send({16'h0000, rows[i].w}, 16);
			expect_w(rows[i].e1, rows[i].e2);
		end
		chk({15'h0000, idle}, 16'h0001);
		$display("test table done");
		send(32'he000, 16);
		host_master_model_i.strobe();
		host_master_model_i.strobe();
		expect_w(8'h83, 8'hff);
		$display("test repeat done");
		send(32'h0000b011, 15);
		expect_w(8'h83, 8'hff);
		send(32'h0001b011, 17);
		expect_w(8'h83, 8'hff);
		send(32'hb022b133, 32);
		chk(host_master_model_i.rx[31:16], 16'h0000);
		chk(host_master_model_i.rx[15:0], 16'hb022);
		expect_w(8'h83, 8'h33);
		$display("test framing done");
		host_master_model_i.cpol = 1'b1;
		send(32'hb055, 16);
		expect_w(8'h55, 8'h33);
		host_master_model_i.cpol = 1'b0;
		$display("test mode done");
		send(32'hb0a5, 16);
		chk(host_master_model_i.rx[15:0], 16'hb055);
		send(32'h9000, 16);
		send(32'h0000, 16);
		chk({8'h00, host_master_model_i.rx[7:0]}, {8'h00, MIDSCALE});
		$display("test readback done");
		write_protect_n = 1'b0;
		send(32'hb011, 16);
		expect_w(8'ha5, 8'h33);
		send(32'h8000, 16);
		expect_w(MIDSCALE, MIDSCALE);
		send(32'h0000, 16);
		write_protect_n = 1'b1;
		$display("test protect done");
		send(32'hb044, 16);
		preset_reload_n = 1'b0;
		pause(8);
		expect_w(MIDSCALE, MIDSCALE);
		preset_reload_n = 1'b1;
		pause(8);
		expect_w(MIDSCALE, MIDSCALE);
		$display("test preset done");
		send(32'hb040, 16);
		send(32'h2000, 16);
		chk({15'h0000, save_done}, 16'h0000);
		send(32'hb011, 16);
		expect_w(8'h40, MIDSCALE);
		chk({15'h0000, save_done}, 16'h0000);
		$display("test save done");
		report_and_stop();
	end
endmodule // tb_wiper_control
